// File: logic/quad_preset_timer.v
// Four-channel one-shot delay timer behind an APB slave.
// Assumes pclk at 250 MHz, presetn from a reset controller,
// ext_adjust driven from outside the clock domain.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "quad_timer_consts.vh"

module quad_preset_timer #(
    parameter TICK_CYCLES = `BASE_TICK_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] ext_adjust,
    output reg  [3:0]  expiry,
    output reg         lamp_active,
    output reg         lamp_expiry,
    output reg         irq
);

// ****************************************************************
// Functions
// ****************************************************************
// Base ticks per unit step for each range code
function [9:0] range_mult;
    input [1:0] sel;
    begin
        case (sel)
            2'd0:    range_mult = `MULT_R0;
            2'd1:    range_mult = `MULT_R1;
            2'd2:    range_mult = `MULT_R2;
            default: range_mult = `MULT_R3;
        endcase
    end
endfunction

// Preset 0..255 maps onto 10..100 steps (10..60 for
// the 10-60 s range), one step being a tenth of the
// range's low end.
function [6:0] step_target;
    input [1:0] sel;
    input [7:0] p;
    reg   [14:0] prod;
    begin
        prod = 15'h0000;
        if (sel == 2'd2)
            prod = p * `SPAN_NARROW;
        else
            prod = p * `SPAN_WIDE;
        step_target = `STEP_LO + prod[14:8];
    end
endfunction

// Only the six word offsets answer; any other address errors
function is_mapped;
    input [7:0] a;
    begin
        case (a)
            `REG_WORD, `REG_CONFIG, `REG_PRESET,
            `REG_INT_STATUS, `REG_INT_ENABLE,
            `REG_INT_CLEAR: is_mapped = 1'b1;
            default:        is_mapped = 1'b0;
        endcase
    end
endfunction

// ****************************************************************
// State
// ****************************************************************
reg  [7:0]  ctl_word;
reg  [11:0] cfg;
reg  [31:0] int_preset;
reg  [31:0] ext_meta;
reg  [31:0] ext_sync;
reg  [3:0]  done;
reg  [3:0]  done_q;
reg  [3:0]  int_status;
reg  [3:0]  int_enable;
reg  [31:0] pre_cnt;
reg         base_tick;
// Per-channel tick and step counters
reg  [9:0]  sub [0:3];
reg  [6:0]  cnt [0:3];
reg  [3:0]  next_status;
reg  [31:0] next_rdata;
integer     i;

wire        setup  = psel & ~penable;
wire        commit = psel & penable & pready;
wire        wr_en  = commit & pwrite;
wire        wr_clr = wr_en & (paddr == `REG_INT_CLEAR);
wire        wr_word = wr_en & (paddr == `REG_WORD);
wire        wr_cfg  = wr_en & (paddr == `REG_CONFIG);
wire        wr_pre  = wr_en & (paddr == `REG_PRESET);
wire        wr_ien  = wr_en & (paddr == `REG_INT_ENABLE);
wire [3:0]  start  = ctl_word[`WORD_START_LSB +: 4];
wire [3:0]  halt   = ctl_word[`WORD_HALT_LSB +: 4];
wire [7:0]  rsel   = cfg[`CFG_RANGE_LSB +: 8];
wire [3:0]  src    = cfg[`CFG_SRC_LSB +: 4];

// ****************************************************************
// Channel targets
// ****************************************************************
// Targets follow the live preset and range, so moving a knob
// mid-run shortens or stretches the delay already under way.
reg  [7:0]  preset_byte [0:3];
reg  [6:0]  target      [0:3];
reg  [9:0]  step_len    [0:3];
integer     j;

always @* begin
    for (j = 0; j < 4; j = j + 1) begin
        preset_byte[j] = src[j] ? int_preset[j*8 +: 8]
                                : ext_sync[j*8 +: 8];
        target[j]      = step_target(rsel[j*2 +: 2], preset_byte[j]);
        step_len[j]    = range_mult(rsel[j*2 +: 2]);
    end
end

// ****************************************************************
// External preset synchroniser
// ****************************************************************
// The adjuster moves slowly; a torn sample lasts one cycle
// and only nudges the target, so no handshake is used.
// Every byte is a separate knob; bits are synced one by one.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ext_meta <= 32'h00000000;
        ext_sync <= 32'h00000000;
    end else if (ce) begin
        ext_meta <= ext_adjust;
        ext_sync <= ext_meta;
    end
end

// ****************************************************************
// APB slave
// ****************************************************************
// Read mux; undecoded offsets read as zero
always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
        `REG_WORD:
            // Start and halt read back as written; top bits stay zero
            next_rdata = {20'h00000, done, ctl_word};
        `REG_CONFIG:     next_rdata = {20'h00000, cfg};
        `REG_PRESET:     next_rdata = int_preset;
        `REG_INT_STATUS: next_rdata = {28'h0000000, int_status};
        `REG_INT_ENABLE: next_rdata = {28'h0000000, int_enable};
        default:         next_rdata = 32'h00000000;
    endcase
end

// Answer registered at setup: access phase sees pready high
// on its first cycle, so every transfer has zero wait states.
// Dropping ce in an access phase holds pready high, so the master
// ends the transfer and the write is lost; keep ce high across a transfer.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
    end else if (ce) begin
        pready <= setup;
        if (setup) begin
            pslverr <= ~is_mapped(paddr);
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
        end else begin
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_word   <= `WORD_RESET;
        cfg        <= `CONFIG_RESET;
        int_preset <= `PRESET_RESET;
        int_enable <= `INT_EN_RESET;
    end else if (ce) begin
        // Writes to INT_STATUS or an unmapped offset are dropped
        if (wr_word)
            ctl_word   <= pwdata[7:0];
        if (wr_cfg)
            cfg        <= pwdata[11:0];
        if (wr_pre)
            int_preset <= pwdata;
        if (wr_ien)
            int_enable <= pwdata[3:0];
    end
end

// ****************************************************************
// Base tick prescaler
// ****************************************************************
// Shared by all channels to save area
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pre_cnt   <= 32'h00000000;
        base_tick <= 1'b0;
    end else if (ce) begin
        if (pre_cnt == TICK_CYCLES - 1) begin
            pre_cnt   <= 32'h00000000;
            base_tick <= 1'b1;
        end else begin
            pre_cnt   <= pre_cnt + 32'h00000001;
            base_tick <= 1'b0;
        end
    end
end

// ****************************************************************
// Timer channels
// ****************************************************************
// Prescaler runs free, so the first step after a start is
// short by up to one base tick (10 ms).
// A done channel ignores its halt bit; done stands until
// software drops the start bit.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        done <= 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            sub[i] <= 10'h000;
            cnt[i] <= 7'h00;
        end
    end else if (ce) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (!start[i]) begin
                sub[i]  <= 10'h000;
                cnt[i]  <= 7'h00;
                done[i] <= 1'b0;
            end else if (!done[i] && !halt[i]) begin
                if (cnt[i] >= target[i]) begin
                    done[i] <= 1'b1;
                end else if (base_tick) begin
                    if (sub[i] == step_len[i] - 10'd1) begin
                        sub[i] <= 10'h000;
                        cnt[i] <= cnt[i] + 7'd1;
                    end else begin
                        sub[i] <= sub[i] + 10'd1;
                    end
                end
            end
        end
    end
end

// ****************************************************************
// Outputs and lamps
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        expiry      <= 4'h0;
        lamp_active <= 1'b0;
        lamp_expiry <= 1'b0;
    end else if (ce) begin
        // One cycle behind done so every pin leaves a flip-flop
        expiry      <= done;
        lamp_expiry <= |done;
        // A halted channel keeps this lamp lit: it is only paused
        lamp_active <= |(start & ~done);
    end
end

// ****************************************************************
// Interrupts
// ****************************************************************
// A new expiry in the clearing cycle survives: set wins.
// Status sets on the rising done edge only, so a done that
// stands does not refill a cleared bit.
wire [3:0]  done_rise = done & ~done_q;

always @* begin
    next_status = int_status;
    if (wr_clr)
        next_status = next_status & ~pwdata[3:0];
    next_status = next_status | done_rise;
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        done_q     <= 4'h0;
        int_status <= 4'h0;
        irq        <= 1'b0;
    end else if (ce) begin
        done_q     <= done;
        int_status <= next_status;
        irq        <= |(int_status & int_enable);
    end
end

endmodule // quad_preset_timer

// File: logic/quad_timer_consts.vh
// Constants for the four-channel preset delay timer.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.
//
// Operation
// - Start bits in word bits 0-3; a set bit starts its channel timing.
// - Halt bits in word bits 4-7; a set bit pauses its channel.
// - Done flags read back in word bits 8-11 once preset elapses.
// - On expiry drive the channel's expiry output and the expiry lamp.
// - Timing-active lamp lights while a started channel is timing.
// - Two-bit range per channel: 0.1-1 s, 1-10 s, 10-60 s, 1-10 min.
// - Source bit per channel: set uses internal preset, clear external.
// - One interface word at a fixed location; bits 12-15 read zero.
`ifndef QUAD_TIMER_CONSTS_VH
`define QUAD_TIMER_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_WORD       8'h00
`define REG_CONFIG     8'h04
`define REG_PRESET     8'h08
`define REG_INT_STATUS 8'h0C
`define REG_INT_ENABLE 8'h10
`define REG_INT_CLEAR  8'h14

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define WORD_START_LSB 0
`define WORD_HALT_LSB  4
`define WORD_DONE_LSB  8
`define CFG_RANGE_LSB  0
`define CFG_SRC_LSB    8
`define WORD_RESET     8'h00
`define CONFIG_RESET   12'h000
`define PRESET_RESET   32'h00000000
`define INT_EN_RESET   4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS  4
`define BASE_TICK_NS   10000000
`define BASE_TICK_CYC  ((`BASE_TICK_NS) / (`CLK_PERIOD_NS))
// Base ticks per unit step, per range code
`define MULT_R0        10'd1
`define MULT_R1        10'd10
`define MULT_R2        10'd100
`define MULT_R3        10'd600
// Unit steps: low end plus scaled preset
`define STEP_LO        7'd10
`define SPAN_WIDE      7'd91
`define SPAN_NARROW    7'd51

`endif

// File: tb/ext_adjuster.sv
// External adjuster knobs on the analogue preset input.
// Assumes the bench sets one knob byte per channel.
`timescale 1ns/1ps
module ext_adjuster (
    input  wire        pclk,
    input  wire [31:0] knob,
    output reg  [31:0] ext_adjust
);
    // Knob settles a cycle late, like a slow resistor
    always @(posedge pclk) begin
        ext_adjust <= knob;
    end
endmodule // ext_adjuster

// File: tb/quad_timer_asserts.sv
// Port-level checks for the quad preset timer.
// Assumes the bench drops ce only between transfers.
`timescale 1ns/1ps
module quad_timer_checker #(
    parameter TICK_CYCLES = 4
) (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  expiry,
    input wire        lamp_active,
    input wire        lamp_expiry,
    input wire        irq
);
    // ****
    // Relations
    // ****
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pready && pwrite;
    ready_next_a: assert property (psel && !penable && ce |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready && ce |=> !pready)
        else $error("ready held too long");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    upper_zero_a: assert property (
        pready && !pwrite && paddr == 8'h00 |-> prdata[31:12] == 20'h0)
        else $error("unused word bits set");
    unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr)
        else $error("no error on unmapped");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    expiry_lamp_a: assert property (
        lamp_expiry == (expiry != 4'h0))
        else $error("expiry lamp mismatch");
    active_lamp_a: assert property (
        wr && paddr == 8'h00 && pwdata[3:0] != 4'h0 |-> ##[1:2] lamp_active)
        else $error("active lamp not lit");
    expiry_clear_a: assert property (
        $fell(expiry[0]) |-> $past(wr && paddr == 8'h00 && !pwdata[0], 3))
        else $error("expiry fell without stop");
    irq_mask_a: assert property (
        wr && paddr == 8'h10 && pwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq not masked");
endmodule // quad_timer_checker

bind quad_preset_timer quad_timer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .expiry(expiry),
    .lamp_active(lamp_active), .lamp_expiry(lamp_expiry), .irq(irq));

// File: tb/tb_top.sv
// Self-checking bench for the quad preset timer.
// Assumes a 4-cycle base tick to keep the run short.
`timescale 1ns/1ps
`include "quad_timer_consts.vh"
module tb_top;
    reg         pclk, presetn, ce, psel, penable, pwrite, err, src;
    reg  [7:0]  paddr, val, inv;
    reg  [31:0] pwdata, knob, rd;
    reg  [35:0] rows [0:3];
    wire [31:0] prdata, ext_adjust;
    wire [3:0]  expiry;
    wire        pready, pslverr, lamp_active, lamp_expiry, irq;
    integer     error_cnt, comparisons, i, n, cyc;

    quad_preset_timer #(.TICK_CYCLES(4)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_adjust(ext_adjust), .expiry(expiry), .lamp_active(lamp_active),
        .lamp_expiry(lamp_expiry), .irq(irq));
    ext_adjuster adj_u (.pclk(pclk), .knob(knob), .ext_adjust(ext_adjust));

    // ****
    // Tasks
    // ****
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // An idle edge keeps the next setup off this release
            @(posedge pclk);
        end
    endtask
    // Counts cycles until channel c expires, capped against hangs
    task wait_exp(input integer c);
        begin
            for (cyc = 0; expiry[c] !== 1'b1 && cyc < 30000; cyc = cyc + 1)
                @(posedge pclk);
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    // ****
    // Stimulus
    // ****
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        #(90000 * 4);
        error_cnt = error_cnt + 1;
        complete_run;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        knob = 32'h0;
        ce = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        // Source, preset byte, steps, ticks per step
        rows[0] = 36'h1_00_0A_0001;
        rows[1] = 36'h0_80_37_000A;
        rows[2] = 36'h1_FF_3C_0064;
        rows[3] = 36'h0_00_0A_0258;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b0, 8'h04 * i + (i == 3 ? 8'h04 : 8'h00), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(err, 1'b1);
        for (i = 0; i < 4; i = i + 1) begin
            src = rows[i][32];
            val = rows[i][31:24];
            inv = ~val;
            n = rows[i][23:16] * rows[i][15:0] * 4;
            knob <= {24'h0, src ? inv : val} << (8 * i);
            apb(1'b1, `REG_CONFIG, (i << (2 * i)) | ({31'h0, src} << (8 + i)));
            apb(1'b1, `REG_PRESET, {24'h0, src ? val : inv} << (8 * i));
            apb(1'b1, `REG_INT_ENABLE, 32'hF);
            apb(1'b1, `REG_WORD, 32'h1 << i);
            wait_exp(i);
            chk(cyc >= n - 4 * rows[i][15:0] && cyc <= n + 8, 1);
            chk({lamp_active, lamp_expiry}, 2'b01);
            apb(1'b0, `REG_WORD, 32'h0);
            chk(rd, (32'h1 << i) | (32'h100 << i));
            apb(1'b0, `REG_INT_STATUS, 32'h0);
            chk(rd, 32'h1 << i);
            chk(irq, 1'b1);
            apb(1'b1, `REG_INT_ENABLE, 32'h0);
            @(posedge pclk);
            chk(irq, 1'b0);
            apb(1'b1, `REG_INT_ENABLE, 32'hF);
            apb(1'b1, `REG_INT_CLEAR, 32'h1 << i);
            apb(1'b1, `REG_WORD, 32'h0);
            repeat (3) @(posedge pclk);
            chk({irq, expiry}, 5'h0);
            apb(1'b0, `REG_WORD, 32'h0);
            chk(rd, 32'h0);
            $display("row %0d finished", i);
        end
        // Started while halted: no progress until the halt lifts
        knob <= 32'h0;
        apb(1'b1, `REG_CONFIG, 32'h0);
        apb(1'b1, `REG_WORD, 32'h11);
        repeat (100) @(posedge pclk);
        chk({lamp_active, expiry[0]}, 2'b10);
        apb(1'b1, `REG_WORD, 32'h1);
        wait_exp(0);
        chk(cyc >= 36 && cyc <= 48, 1);
        $display("halt test finished");
        // Clock enable low freezes the count mid-run
        apb(1'b1, `REG_WORD, 32'h0);
        apb(1'b1, `REG_WORD, 32'h1);
        ce <= 1'b0;
        repeat (200) @(posedge pclk);
        chk({lamp_active, expiry[0]}, 2'b10);
        ce <= 1'b1;
        wait_exp(0);
        chk(cyc >= 30 && cyc <= 48, 1);
        $display("ce test finished");
        // Reset with channel 0 expired and still started clears irq, lamps, expiry, the word and the interrupt status
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({irq, lamp_active, lamp_expiry, expiry}, 7'h00);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `REG_WORD, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `REG_INT_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("reset test finished");
        complete_run;
    end
endmodule // tb_top
